// ---- dv/scasr_ctrl_tb_top.sv ----
/*
 self-checking bench of the shift register control block.
 assumes the controller model drives every pin but core_clk_i and rst_i; outputs settle within 8 cycles.
*/
`timescale 1ns/100ps
module scasr_ctrl_tb_top;
	logic        core_clk_i, rst_i, wen, we, wclk, sdi, clr_n, rclk, rev;
	logic        wso, rso, run, csv;
	logic [11:0] chw, q;
	logic [9:0]  cs;
	int          bad_count, num_checks;
	scasr_ctrl scasr_ctrl_i(.core_clk_i(core_clk_i), .rst_i(rst_i), .wave_enable_in_i(wen),
		.write_enable_in_i(we), .write_reg_shift_clock_i(wclk), .shared_serial_data_in_i(sdi),
		.read_reg_clear_n_i(clr_n), .read_reg_shift_clock_i(rclk), .wave_revolution_i(rev),
		.write_reg_serial_out_o(wso), .read_reg_serial_out_o(rso), .channel_write_o(chw),
		.wave_running_o(run), .cell_select_o(cs), .cell_select_valid_o(csv));
	scasr_fpga_model scasr_fpga_model_i(.wso_i(wso), .cell_i(cs), .wave_en_o(wen),
		.wr_en_o(we), .wclk_o(wclk), .sdata_o(sdi), .clr_n_o(clr_n), .rclk_o(rclk), .rev_o(rev));
	initial
	begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic t_load;
		scasr_fpga_model_i.load_pat(12'hAAA);
		check(16'(wso), 16'h0001);
		scasr_fpga_model_i.levels(1'b1, 1'b1);
		check(16'(run), 16'h0001);
		check(16'(chw), 16'h0AAA);
		scasr_fpga_model_i.revolve();
		check(16'(chw), 16'h0555);
		scasr_fpga_model_i.levels(1'b1, 1'b0);
		check(16'(chw), 16'h0000);
		scasr_fpga_model_i.levels(1'b0, 1'b0);
		check(16'(run), 16'h0000);
		scasr_fpga_model_i.read_back(12, q);
		check(16'(q), 16'h0555);
		scasr_fpga_model_i.read_back(24, q);
		check(16'(q), 16'h0555);
	endtask
	task automatic t_walk(input logic [11:0] p);
		logic [11:0] want;
		want = p;
		scasr_fpga_model_i.load_pat(p);
		scasr_fpga_model_i.levels(1'b1, 1'b1);
		for (int i = 1; i <= 12; i++)
		begin
			scasr_fpga_model_i.revolve();
			want = {want[10:0], want[11]};
			if (p == 12'hFFF)
				check(16'(chw), 16'h0FFF);
			else
				check(16'($countones(chw)), 16'h0001);
			check(16'(chw), 16'(want));
		end
		check(16'(chw), 16'(p));
		scasr_fpga_model_i.levels(1'b0, 1'b0);
	endtask
	task automatic t_read;
		realtime t0;
		t0 = $realtime;
		scasr_fpga_model_i.clear(1'b0);
		check(16'(rso), 16'h0000);
		scasr_fpga_model_i.clk_bit(1'b1, 1'b1);
		check(16'(csv), 16'h0000);
		for (int i = 1; i < 1024; i++)
		begin
			scasr_fpga_model_i.clk_bit(1'b1, 1'b0);
			check(16'(cs), 16'(i - 1));
			check(16'(csv), 16'h0001);
			check(16'(rso), 16'(i == 1023));
			check(16'(scasr_fpga_model_i.adc_cell), 16'(i - 1));
			check(scasr_fpga_model_i.corrected, 16'(i - 1));
		end
		check(16'($realtime - t0 < 1.0e6), 16'h0001);
		scasr_fpga_model_i.clear(1'b1);
		check(16'(rso), 16'h0001);
		scasr_fpga_model_i.clear(1'b0);
		check(16'(rso), 16'h0000);
	endtask
	initial
	begin
		rst_i = 1'b1;
		repeat (20) @(posedge core_clk_i);
		#1 rst_i = 1'b0;
		repeat (3) @(posedge core_clk_i);
		t_load();
		t_walk(12'h800);
		t_walk(12'hFFF);
		t_read();
		complete_run();
	end
	initial
	begin
		#300000;
		bad_count++;
		complete_run();
	end
endmodule

// ---- dv/scasr_fpga_model.sv ----
/*
 readout controller model: drives the pins of the shift register control block.
 assumes the bench calls its tasks one at a time; link clock period 125 ns.
*/
`timescale 1ns/100ps
module scasr_fpga_model
(
	input  wire logic       wso_i,     // write reg serial out
	input  wire logic [9:0] cell_i,    // cell on analog mux
	output logic            wave_en_o, // wave run
	output logic            wr_en_o,   // write gate
	output logic            wclk_o,    // write reg clock
	output logic            sdata_o,   // serial data
	output logic            clr_n_o,   // read reg clear
	output logic            rclk_o,    // read reg clock
	output logic            rev_o      // revolution toggle
);
	logic [9:0]  cell_idx;       // controller's own cell count
	logic [9:0]  adc_cell;       // cell seen at the adc strike
	logic [15:0] corrected;      // sample less its cell offset
	logic [15:0] ofs_tbl [1024]; // fixed offset per cell
	initial
	begin
		{wave_en_o, wr_en_o, wclk_o, sdata_o, rclk_o, rev_o} = 6'h00;
		clr_n_o = 1'b1;
		cell_idx = '1;
		adc_cell = '0;
		corrected = '0;
		for (int k = 0; k < 1024; k++)
			ofs_tbl[k] = 16'(k % 7);
	end
	// rise with data change, adc strike, fall mid period
	task automatic clk_bit(input logic rd, input logic b);
		if (rd)
			rclk_o = 1'b1;
		else
			wclk_o = 1'b1;
		sdata_o = b;
		#38;
		// stand-in sample: cell number plus that cell's offset
		if (rd)
		begin
			adc_cell = cell_i;
			corrected = 16'(cell_i) + ofs_tbl[cell_i] - ofs_tbl[cell_idx];
			cell_idx = cell_idx + 10'h001;
		end
		#24.5;
		if (rd)
			rclk_o = 1'b0;
		else
			wclk_o = 1'b0;
		#62.5;
	endtask
	task automatic levels(input logic run, input logic w);
		wave_en_o = run;
		wr_en_o = w;
		#125;
	endtask
	task automatic load_pat(input logic [11:0] p);
		wr_en_o = 1'b1;
		for (int i = 11; i >= 0; i--) clk_bit(1'b0, p[i]);
		wr_en_o = 1'b0;
		sdata_o = ~sdata_o; // released line
	endtask
	task automatic read_back(input int n, output logic [11:0] q);
		logic b;
		wr_en_o = 1'b1;
		for (int i = 0; i < n; i++)
		begin
			b = wso_i;
			q = {q[10:0], b};
			clk_bit(1'b0, b);
		end
		wr_en_o = 1'b0;
		sdata_o = ~sdata_o;
	endtask
	task automatic clear(input logic d);
		sdata_o = d;
		rclk_o = 1'b0;
		cell_idx = '1;
		clr_n_o = 1'b0;
		#40 clr_n_o = 1'b1;
		#85;
	endtask
	task automatic revolve;
		rev_o = ~rev_o;
		#125;
	endtask
endmodule

// ---- verilog/scasr_ctrl.sv ----
/*
 digital shift register control of a 12 channel switched capacitor sampler.
 all pins are asynchronous to core_clk_i; all but rst_i are synchronised here; the wave
 revolution strobe comes from the analog wave circuit, also asynchronous.
*/
`timescale 1ns/100ps
`include "scasr_defs.svh"
module scasr_ctrl
	import scasr_pkg::*;
(
	input  wire logic                           core_clk_i,                // 125 MHz
	input  wire logic                           rst_i,                     // async, high
	input  wire logic                           wave_enable_in_i,          // wave run pin
	input  wire logic                           write_enable_in_i,         // write gate pin
	input  wire logic                           write_reg_shift_clock_i,   // write reg clock
	input  wire logic                           shared_serial_data_in_i,   // serial data
	input  wire logic                           read_reg_clear_n_i,        // read reg clear
	input  wire logic                           read_reg_shift_clock_i,    // read reg clock
	input  wire logic                           wave_revolution_i,         // wave wrap strobe
	output logic                                write_reg_serial_out_o,    // pattern msb
	output logic                                read_reg_serial_out_o,     // last read cell
	output logic [`SCASR_NUM_CHANNELS-1:0]      channel_write_o,           // switch enables
	output logic                                wave_running_o,            // wave active
	output logic [`SCASR_CELL_IDX_W-1:0]        cell_select_o,             // cell on mux out
	output logic                                cell_select_valid_o        // read bit present
);
	scasr_state_t st_ff;
	scasr_state_t nxt_st;

	function automatic logic [`SCASR_CELL_IDX_W-1:0] find_cell(
		input logic [`SCASR_NUM_CELLS-1:0] sr);
		logic [`SCASR_CELL_IDX_W-1:0] idx;
		idx = '0;
		for (int i = 0; i < `SCASR_NUM_CELLS; i++)
		begin
			if (sr[i])
			begin
				idx = i[`SCASR_CELL_IDX_W-1:0];
			end
		end
		return idx;
	endfunction

	logic wclk_fall;
	logic rclk_fall;
	logic rclk_rise;
	logic rev_edge;
	logic clr_act;
	logic clr_done;

	always_comb
	begin
		wclk_fall = st_ff.prev.write_reg_shift_clock & ~st_ff.s2.write_reg_shift_clock;
		rclk_fall = st_ff.prev.read_reg_shift_clock & ~st_ff.s2.read_reg_shift_clock;
		rclk_rise = ~st_ff.prev.read_reg_shift_clock & st_ff.s2.read_reg_shift_clock;
		rev_edge  = st_ff.prev.revolution ^ st_ff.s2.revolution;
		clr_act   = ~st_ff.s2.read_reg_clear_n & ~st_ff.s2.read_reg_shift_clock
			& ~st_ff.s2.shared_serial_data_in;
		clr_done  = (st_ff.clear_cnt == `SCASR_CLEAR_CNT_W'(`SCASR_CLEAR_MIN_CYC - 1));

		nxt_st = st_ff;
		nxt_st.s1.wave_enable_in        = wave_enable_in_i;
		nxt_st.s1.write_enable_in       = write_enable_in_i;
		nxt_st.s1.write_reg_shift_clock = write_reg_shift_clock_i;
		nxt_st.s1.shared_serial_data_in = shared_serial_data_in_i;
		nxt_st.s1.read_reg_clear_n      = read_reg_clear_n_i;
		nxt_st.s1.read_reg_shift_clock  = read_reg_shift_clock_i;
		nxt_st.s1.revolution            = wave_revolution_i;
		nxt_st.s2   = st_ff.s1;
		nxt_st.prev = st_ff.s2;

		// wave runs while enable high; rise starts it, low stops it
		nxt_st.wave_run = st_ff.s2.wave_enable_in;

		// write pattern: serial load on falling clock, else rotate per revolution
		if (st_ff.s2.write_enable_in && wclk_fall)
		begin
			nxt_st.write_pat = {st_ff.write_pat[`SCASR_NUM_CHANNELS-2:0],
				st_ff.s2.shared_serial_data_in};
		end
		else if (st_ff.wave_run && rev_edge)
		begin
			nxt_st.write_pat = {st_ff.write_pat[`SCASR_NUM_CHANNELS-2:0],
				st_ff.write_pat[`SCASR_NUM_CHANNELS-1]};
		end
		// msb leaves first after twelve clocks
		nxt_st.write_reg_serial_out = nxt_st.write_pat[`SCASR_NUM_CHANNELS-1];

		// channel gate: pattern bit and write enable and running wave
		nxt_st.channel_write = (st_ff.wave_run && st_ff.s2.write_enable_in)
			? st_ff.write_pat : '0;

		// read register clear needs a stable low for the minimum time
		if (clr_act)
		begin
			if (!clr_done)
			begin
				nxt_st.clear_cnt = st_ff.clear_cnt + `SCASR_CLEAR_CNT_W'(1);
			end
			else
			begin
				nxt_st.read_sr = '0;
			end
		end
		else
		begin
			nxt_st.clear_cnt = '0;
			if (rclk_fall)
			begin
				nxt_st.read_sr = {st_ff.read_sr[`SCASR_NUM_CELLS-2:0],
					st_ff.s2.shared_serial_data_in};
			end
		end
		nxt_st.read_reg_serial_out = nxt_st.read_sr[`SCASR_NUM_CELLS-1];

		// next cell onto the analog mux at the rising read clock
		if (rclk_rise)
		begin
			nxt_st.cell_select       = find_cell(st_ff.read_sr);
			nxt_st.cell_select_valid = |st_ff.read_sr;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_ff <= '{
				s1: '0, s2: '0, prev: '0,
				write_pat: `SCASR_WRITE_PAT_RESET,
				read_sr: '0, clear_cnt: '0, wave_run: 1'b0,
				write_reg_serial_out: 1'b0, read_reg_serial_out: 1'b0,
				channel_write: '0, cell_select: '0, cell_select_valid: 1'b0};
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign write_reg_serial_out_o = st_ff.write_reg_serial_out;
	assign read_reg_serial_out_o  = st_ff.read_reg_serial_out;
	assign channel_write_o        = st_ff.channel_write;
	assign wave_running_o         = st_ff.wave_run;
	assign cell_select_o          = st_ff.cell_select;
	assign cell_select_valid_o    = st_ff.cell_select_valid;

	sequence seq_wclk_fall_we;
		st_ff.s2.write_enable_in && wclk_fall;
	endsequence

	AST_WRITE_CAPTURE: assert property (@(posedge core_clk_i) disable iff (rst_i)
		seq_wclk_fall_we |=> st_ff.write_pat[0] == $past(st_ff.s2.shared_serial_data_in))
		else $error("serial bit not captured on write clock fall");

	AST_ROTATE: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(!(st_ff.s2.write_enable_in && wclk_fall) && st_ff.wave_run && rev_edge)
		|=> st_ff.write_pat == {$past(st_ff.write_pat[10:0]), $past(st_ff.write_pat[11])})
		else $error("pattern not rotated on revolution");

	AST_ALL_ONES: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(&st_ff.write_pat && !(st_ff.s2.write_enable_in && wclk_fall))
		|=> &st_ff.write_pat)
		else $error("all ones pattern lost");

	AST_ONE_WALK: assert property (@(posedge core_clk_i) disable iff (rst_i)
		($onehot(st_ff.write_pat) && !(st_ff.s2.write_enable_in && wclk_fall))
		|=> $onehot(st_ff.write_pat))
		else $error("single channel bit lost");

	AST_GATE: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!(st_ff.wave_run && st_ff.s2.write_enable_in) |=> channel_write_o == '0)
		else $error("channel writing while stopped");

	AST_GATE_ON: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(st_ff.wave_run && st_ff.s2.write_enable_in)
		|=> channel_write_o == $past(st_ff.write_pat))
		else $error("write enable did not route pattern");

	AST_WAVE: assert property (@(posedge core_clk_i) disable iff (rst_i)
		$rose(st_ff.s2.wave_enable_in) |=> wave_running_o)
		else $error("wave did not start");

	AST_READ_LOAD: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(rclk_fall && !clr_act) |=> st_ff.read_sr[0] == $past(st_ff.s2.shared_serial_data_in))
		else $error("read bit not loaded on read clock fall");

	AST_CLEAR: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(clr_act && clr_done) |=> st_ff.read_sr == '0)
		else $error("read register not cleared");

	AST_MSB_OUT: assert property (@(posedge core_clk_i) disable iff (rst_i)
		##1 write_reg_serial_out_o == st_ff.write_pat[11])
		else $error("write out not pattern msb");

	AST_READ_OUT: assert property (@(posedge core_clk_i) disable iff (rst_i)
		read_reg_serial_out_o == st_ff.read_sr[`SCASR_NUM_CELLS-1])
		else $error("read out not last cell");

	AST_CELL_SEL: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(rclk_rise && st_ff.read_sr[0] && !(|st_ff.read_sr[`SCASR_NUM_CELLS-1:1]))
		|=> cell_select_o == '0 && cell_select_valid_o)
		else $error("cell select wrong after rise");
endmodule

// ---- verilog/scasr_defs.svh ----
/*
 shift register control constants: widths, depths, reset pattern, timing counts.
 assumes inclusion by the scasr package and the top module.
*/
`ifndef SCASR_DEFS_SVH
`define SCASR_DEFS_SVH
`define SCASR_NUM_CHANNELS      12
`define SCASR_NUM_CELLS         1024
`define SCASR_CELL_IDX_W        10
`define SCASR_WRITE_PAT_RESET   12'h000
`define SCASR_CLEAR_MIN_NS      10
`define SCASR_CLK_PERIOD_NS     8
`define SCASR_CLEAR_MIN_CYC     ((`SCASR_CLEAR_MIN_NS + `SCASR_CLK_PERIOD_NS - 1) / `SCASR_CLK_PERIOD_NS)
`define SCASR_CLEAR_CNT_W       4
`endif

// ---- verilog/scasr_pkg.sv ----
/*
 types of the sampler shift register control block.
 assumes the defs header is on the include path.
*/
`include "scasr_defs.svh"
package scasr_pkg;
	typedef struct packed {
		logic wave_enable_in;
		logic write_enable_in;
		logic write_reg_shift_clock;
		logic shared_serial_data_in;
		logic read_reg_clear_n;
		logic read_reg_shift_clock;
		logic revolution;
	} scasr_pins_t;

	typedef struct packed {
		scasr_pins_t                    s1;
		scasr_pins_t                    s2;
		scasr_pins_t                    prev;
		logic [`SCASR_NUM_CHANNELS-1:0] write_pat;
		logic [`SCASR_NUM_CELLS-1:0]    read_sr;
		logic [`SCASR_CLEAR_CNT_W-1:0]  clear_cnt;
		logic                           wave_run;
		logic                           write_reg_serial_out;
		logic                           read_reg_serial_out;
		logic [`SCASR_NUM_CHANNELS-1:0] channel_write;
		logic [`SCASR_CELL_IDX_W-1:0]   cell_select;
		logic                           cell_select_valid;
	} scasr_state_t;
endpackage
